/* File: include/hsr_pkg.sv */
// Constants, offsets and field layouts shared by the hierarchical status reporting block.
package hsr_pkg;
  localparam int REG_W = 16;
  localparam int STAT_W = 15;
  localparam int BYTE_W = 8;
  localparam int NUM_GRP = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IRQ_W = 2;

  localparam logic [ADDR_W-1:0] OFS_STB = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SPOLL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SRE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ESR = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_ESE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CLS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h1c;
  localparam int GRP_SEL_BIT = 7;
  localparam int GRP_IDX_LSB = 5;
  localparam logic [4:0] GOFS_COND = 5'h00;
  localparam logic [4:0] GOFS_PTR = 5'h04;
  localparam logic [4:0] GOFS_NTR = 5'h08;
  localparam logic [4:0] GOFS_EVT = 5'h0c;
  localparam logic [4:0] GOFS_EN = 5'h10;

  localparam int GRP_OPER = 0;
  localparam int GRP_QUES = 1;
  localparam int GRP_FREQ = 2;
  localparam int GRP_POW = 3;

  localparam int OPER_SETTLE_BIT = 1;
  localparam int QUES_POW_BIT = 3;
  localparam int QUES_FREQ_BIT = 5;
  localparam int STB_ERR_BIT = 2;
  localparam int STB_QUES_BIT = 3;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_RQS_BIT = 6;
  localparam int STB_OPER_BIT = 7;
  localparam int IRQ_SRQ_BIT = 0;
  localparam int IRQ_SPOLL_BIT = 1;

  localparam logic [STAT_W-1:0] PTR_RST = 15'h7fff;
  localparam logic [STAT_W-1:0] NTR_RST = 15'h0000;
  localparam logic [STAT_W-1:0] EVT_RST = 15'h0000;
  localparam logic [STAT_W-1:0] EN_RST = 15'h0000;
  localparam logic [BYTE_W-1:0] SRE_RST = 8'h00;
  localparam logic [BYTE_W-1:0] ESE_RST = 8'h00;
  localparam logic [BYTE_W-1:0] ESR_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : hsr_pkg

/* File: rtl/hsr_group.sv */
// One status group: condition, transition filters, sticky event, enable and summary.
`timescale 1ns/10ps
module hsr_group (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [hsr_pkg::STAT_W-1:0] i_cond,
  input wire logic i_wr_ptr,
  input wire logic i_wr_ntr,
  input wire logic i_wr_en,
  input wire logic [hsr_pkg::REG_W-1:0] i_wdata,
  input wire logic [hsr_pkg::REG_W-1:0] i_wmask,
  input wire logic i_rd_clr,
  input wire logic i_cls,
  output logic [hsr_pkg::STAT_W-1:0] o_cond,
  output logic [hsr_pkg::STAT_W-1:0] o_ptr,
  output logic [hsr_pkg::STAT_W-1:0] o_ntr,
  output logic [hsr_pkg::STAT_W-1:0] o_event,
  output logic [hsr_pkg::STAT_W-1:0] o_enable,
  output logic o_summary
);
  import hsr_pkg::*;

  logic [STAT_W-1:0] cond_nxt;
  logic [STAT_W-1:0] ptr_nxt;
  logic [STAT_W-1:0] ntr_nxt;
  logic [STAT_W-1:0] evt_nxt;
  logic [STAT_W-1:0] en_nxt;
  logic [STAT_W-1:0] wd;
  logic [STAT_W-1:0] wm;
  logic [STAT_W-1:0] hit;
  logic sum_nxt;

  always_comb begin
    wd = i_wdata[STAT_W-1:0];
    wm = i_wmask[STAT_W-1:0];
    cond_nxt = i_cond;
    ptr_nxt = o_ptr;
    ntr_nxt = o_ntr;
    en_nxt = o_enable;
    if (i_wr_ptr) begin
      ptr_nxt = (o_ptr & ~wm) | (wd & wm);
    end
    if (i_wr_ntr) begin
      ntr_nxt = (o_ntr & ~wm) | (wd & wm);
    end
    if (i_wr_en) begin
      en_nxt = (o_enable & ~wm) | (wd & wm);
    end
    hit = (i_cond & ~o_cond & o_ptr) | (~i_cond & o_cond & o_ntr);
    evt_nxt = o_event;
    if (i_rd_clr || i_cls) begin
      evt_nxt = '0;
    end
    evt_nxt = evt_nxt | hit;
    sum_nxt = |(evt_nxt & en_nxt);
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cond <= '0;
      o_ptr <= PTR_RST;
      o_ntr <= NTR_RST;
      o_event <= EVT_RST;
      o_enable <= EN_RST;
      o_summary <= 1'b0;
    end else begin
      o_cond <= cond_nxt;
      o_ptr <= ptr_nxt;
      o_ntr <= ntr_nxt;
      o_event <= evt_nxt;
      o_enable <= en_nxt;
      o_summary <= sum_nxt;
    end
  end
endmodule : hsr_group

/* File: rtl/hsr_top.sv */
// Status register hierarchy with status byte, service request and AXI4-Lite register slave.
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
// Operation
// - Lower group summaries drive higher register bits.
// - Status byte gathers operation and questionable summaries; frequency and power reach it through questionable.
// - Groups by function: operation, questionable, frequency, power.
// - Frequency questionable group has five registers.
// - Status words use binary weighted bits.
// - Bit fifteen always reads as zero.
// - Written weight sum enables exactly those bits.
// - Reads return the set bits as value.
// - Common and subsystem commands decoded separately.
// - Settling reported in operation condition register.
// - Service request notifies controller without polling.
// - Condition bits follow live condition.
// - Events stick until read or clear.
// - Filters default rising, configurable falling or both.
// - Serial poll clears request bit only.
module hsr_top (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [hsr_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [hsr_pkg::DATA_W-1:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [hsr_pkg::ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [hsr_pkg::DATA_W-1:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic [hsr_pkg::STAT_W-1:0] i_oper_cond,
  input wire logic i_settling,
  input wire logic [hsr_pkg::STAT_W-1:0] i_ques_cond,
  input wire logic [hsr_pkg::STAT_W-1:0] i_freq_cond,
  input wire logic [hsr_pkg::STAT_W-1:0] i_pow_cond,
  input wire logic [hsr_pkg::BYTE_W-1:0] i_std_event,
  input wire logic i_err_avail,
  input wire logic i_msg_avail,
  output logic o_srq,
  output logic o_irq
);
  import hsr_pkg::*;

  logic aw_full_r, aw_full_nxt;
  logic w_full_r, w_full_nxt;
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic [DATA_W-1:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic do_write;
  logic ar_take;

  logic [REG_W-1:0] wmask;
  logic [REG_W-1:0] wval;
  logic wr_ok, wr_sre, wr_ese, wr_cls, wr_imask, wr_istat;
  logic [NUM_GRP-1:0] wr_ptr, wr_ntr, wr_en;
  logic rd_ok, rd_spoll, rd_esr;
  logic [NUM_GRP-1:0] rd_clr;
  logic [REG_W-1:0] rd_val;
  logic [1:0] rgi;
  logic [1:0] wgi;

  logic [STAT_W-1:0] g_cond_in [NUM_GRP];
  logic [STAT_W-1:0] g_cond [NUM_GRP];
  logic [STAT_W-1:0] g_ptr [NUM_GRP];
  logic [STAT_W-1:0] g_ntr [NUM_GRP];
  logic [STAT_W-1:0] g_evt [NUM_GRP];
  logic [STAT_W-1:0] g_en [NUM_GRP];
  logic [NUM_GRP-1:0] g_sum;

  logic [BYTE_W-1:0] sre_r, sre_nxt;
  logic [BYTE_W-1:0] ese_r, ese_nxt;
  logic [BYTE_W-1:0] esr_r, esr_nxt;
  logic rqs_r, rqs_nxt;
  logic req_prev_r, req_prev_nxt;
  logic [IRQ_W-1:0] istat_r, istat_nxt;
  logic [IRQ_W-1:0] imask_r, imask_nxt;
  logic irq_r, irq_nxt;
  logic [BYTE_W-1:0] stb;
  logic req_now;
  logic req_rise;
  logic [IRQ_W-1:0] iset;

  // Bus handshake: address and data are held until both are present.
  assign do_write = aw_full_r && w_full_r && !bvalid_r;
  assign ar_take = i_arvalid && arready_r;

  always_comb begin
    aw_full_nxt = (aw_full_r || (i_awvalid && awready_r)) && !do_write;
    w_full_nxt = (w_full_r || (i_wvalid && wready_r)) && !do_write;
    aw_addr_nxt = (i_awvalid && awready_r) ? i_awaddr : aw_addr_r;
    w_data_nxt = (i_wvalid && wready_r) ? i_wdata : w_data_r;
    w_strb_nxt = (i_wvalid && wready_r) ? i_wstrb : w_strb_r;
    awready_nxt = !aw_full_nxt;
    wready_nxt = !w_full_nxt;
    bvalid_nxt = do_write || (bvalid_r && !i_bready);
    bresp_nxt = do_write ? (wr_ok ? RESP_OKAY : RESP_SLVERR) : bresp_r;
    rvalid_nxt = ar_take || (rvalid_r && !i_rready);
    arready_nxt = !rvalid_nxt;
    rdata_nxt = ar_take ? {{(DATA_W-REG_W){1'b0}}, rd_val} : rdata_r;
    rresp_nxt = ar_take ? (rd_ok ? RESP_OKAY : RESP_SLVERR) : rresp_r;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // Write decode: common registers low, subsystem groups above the group select bit.
  always_comb begin
    wmask = {{BYTE_W{w_strb_r[1]}}, {BYTE_W{w_strb_r[0]}}};
    wval = w_data_r[REG_W-1:0];
    wgi = aw_addr_r[GRP_IDX_LSB+1:GRP_IDX_LSB];
    wr_ok = 1'b1;
    wr_sre = 1'b0;
    wr_ese = 1'b0;
    wr_cls = 1'b0;
    wr_imask = 1'b0;
    wr_istat = 1'b0;
    wr_ptr = '0;
    wr_ntr = '0;
    wr_en = '0;
    if (aw_addr_r[GRP_SEL_BIT]) begin
      if (aw_addr_r[4:0] == GOFS_PTR) begin
        wr_ptr[wgi] = do_write;
      end else if (aw_addr_r[4:0] == GOFS_NTR) begin
        wr_ntr[wgi] = do_write;
      end else if (aw_addr_r[4:0] == GOFS_EN) begin
        wr_en[wgi] = do_write;
      end else begin
        wr_ok = 1'b0;
      end
    end else if (aw_addr_r == OFS_SRE) begin
      wr_sre = do_write;
    end else if (aw_addr_r == OFS_ESE) begin
      wr_ese = do_write;
    end else if (aw_addr_r == OFS_CLS) begin
      wr_cls = do_write;
    end else if (aw_addr_r == OFS_IRQ_STAT) begin
      wr_istat = do_write;
    end else if (aw_addr_r == OFS_IRQ_MASK) begin
      wr_imask = do_write;
    end else begin
      wr_ok = 1'b0;
    end
  end

  // Read decode: values are the plain binary sum of set bits, bit fifteen zero.
  always_comb begin
    rgi = i_araddr[GRP_IDX_LSB+1:GRP_IDX_LSB];
    rd_val = '0;
    rd_ok = 1'b1;
    rd_spoll = 1'b0;
    rd_esr = 1'b0;
    rd_clr = '0;
    if (i_araddr[GRP_SEL_BIT]) begin
      if (i_araddr[4:0] == GOFS_COND) begin
        rd_val = {1'b0, g_cond[rgi]};
      end else if (i_araddr[4:0] == GOFS_PTR) begin
        rd_val = {1'b0, g_ptr[rgi]};
      end else if (i_araddr[4:0] == GOFS_NTR) begin
        rd_val = {1'b0, g_ntr[rgi]};
      end else if (i_araddr[4:0] == GOFS_EVT) begin
        rd_val = {1'b0, g_evt[rgi]};
        rd_clr[rgi] = ar_take;
      end else if (i_araddr[4:0] == GOFS_EN) begin
        rd_val = {1'b0, g_en[rgi]};
      end else begin
        rd_ok = 1'b0;
      end
    end else if (i_araddr == OFS_STB) begin
      rd_val = {8'h00, stb[7], req_now, stb[5:0]};
    end else if (i_araddr == OFS_SPOLL) begin
      rd_val = {8'h00, stb[7], rqs_r, stb[5:0]};
      rd_spoll = ar_take;
    end else if (i_araddr == OFS_SRE) begin
      rd_val = {8'h00, sre_r};
    end else if (i_araddr == OFS_ESR) begin
      rd_val = {8'h00, esr_r};
      rd_esr = ar_take;
    end else if (i_araddr == OFS_ESE) begin
      rd_val = {8'h00, ese_r};
    end else if (i_araddr == OFS_IRQ_STAT) begin
      rd_val = {{(REG_W-IRQ_W){1'b0}}, istat_r};
    end else if (i_araddr == OFS_IRQ_MASK) begin
      rd_val = {{(REG_W-IRQ_W){1'b0}}, imask_r};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Condition inputs of each group, with lower summaries folded into higher ones.
  always_comb begin
    g_cond_in[GRP_OPER] = i_oper_cond;
    g_cond_in[GRP_OPER][OPER_SETTLE_BIT] = i_settling;
    g_cond_in[GRP_QUES] = i_ques_cond;
    g_cond_in[GRP_QUES][QUES_POW_BIT] = g_sum[GRP_POW];
    g_cond_in[GRP_QUES][QUES_FREQ_BIT] = g_sum[GRP_FREQ];
    g_cond_in[GRP_FREQ] = i_freq_cond;
    g_cond_in[GRP_POW] = i_pow_cond;
  end

  // Each group holds condition, two filters, event and enable.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_GRP; gi++) begin : g_grp
      hsr_group u_group (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_cond(g_cond_in[gi]),
        .i_wr_ptr(wr_ptr[gi]),
        .i_wr_ntr(wr_ntr[gi]),
        .i_wr_en(wr_en[gi]),
        .i_wdata(wval),
        .i_wmask(wmask),
        .i_rd_clr(rd_clr[gi]),
        .i_cls(wr_cls),
        .o_cond(g_cond[gi]),
        .o_ptr(g_ptr[gi]),
        .o_ntr(g_ntr[gi]),
        .o_event(g_evt[gi]),
        .o_enable(g_en[gi]),
        .o_summary(g_sum[gi])
      );
    end
  endgenerate

  // Status byte and service request.
  always_comb begin
    stb = '0;
    stb[STB_ERR_BIT] = i_err_avail;
    stb[STB_QUES_BIT] = g_sum[GRP_QUES];
    stb[STB_MAV_BIT] = i_msg_avail;
    stb[STB_ESB_BIT] = |(esr_r & ese_r);
    stb[STB_OPER_BIT] = g_sum[GRP_OPER];
    req_now = |(stb & sre_r & ~(8'h01 << STB_RQS_BIT));
    req_rise = req_now && !req_prev_r;
    req_prev_nxt = req_now;
    rqs_nxt = (rqs_r && !rd_spoll) || req_rise;
    sre_nxt = wr_sre ? ((sre_r & ~wmask[BYTE_W-1:0]) | (wval[BYTE_W-1:0] & wmask[BYTE_W-1:0])) : sre_r;
    ese_nxt = wr_ese ? ((ese_r & ~wmask[BYTE_W-1:0]) | (wval[BYTE_W-1:0] & wmask[BYTE_W-1:0])) : ese_r;
    esr_nxt = ((rd_esr || wr_cls) ? ESR_RST : esr_r) | i_std_event;
    iset = '0;
    iset[IRQ_SRQ_BIT] = req_rise && !rqs_r;
    iset[IRQ_SPOLL_BIT] = rd_spoll;
    istat_nxt = (wr_istat ? (istat_r & ~wval[IRQ_W-1:0]) : istat_r) | iset;
    imask_nxt = wr_imask ? wval[IRQ_W-1:0] : imask_r;
    irq_nxt = |(istat_nxt & imask_nxt);
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sre_r <= SRE_RST;
      ese_r <= ESE_RST;
      esr_r <= ESR_RST;
      rqs_r <= 1'b0;
      req_prev_r <= 1'b0;
      istat_r <= IRQ_RST;
      imask_r <= IRQ_RST;
      irq_r <= 1'b0;
    end else begin
      sre_r <= sre_nxt;
      ese_r <= ese_nxt;
      esr_r <= esr_nxt;
      rqs_r <= rqs_nxt;
      req_prev_r <= req_prev_nxt;
      istat_r <= istat_nxt;
      imask_r <= imask_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign o_awready = awready_r;
  assign o_wready = wready_r;
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_arready = arready_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;
  assign o_srq = rqs_r;
  assign o_irq = irq_r;
endmodule : hsr_top

/* File: testbench/hsr_ctrl_model.sv */
// Register bus master standing in for the remote controller.
`timescale 1ns/10ps
module hsr_ctrl_model (
  input wire logic i_sys_clk,
  input wire logic i_awready,
  input wire logic i_wready,
  input wire logic i_bvalid,
  input wire logic i_arready,
  input wire logic i_rvalid,
  output logic o_awvalid,
  output logic [hsr_pkg::ADDR_W-1:0] o_awaddr,
  output logic o_wvalid,
  output logic [hsr_pkg::DATA_W-1:0] o_wdata,
  output logic [3:0] o_wstrb,
  output logic o_bready,
  output logic o_arvalid,
  output logic [hsr_pkg::ADDR_W-1:0] o_araddr,
  output logic o_rready
);
  import hsr_pkg::*;
  initial begin
    {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
    o_awaddr = 8'h00;
    o_araddr = 8'h00;
    o_wdata = 32'h00000000;
    o_wstrb = 4'hf;
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [3:0] s = 4'hf);
    logic done = 1'b0;
    @(posedge i_sys_clk);
    o_awaddr <= a;
    o_wdata <= d;
    o_wstrb <= s;
    o_awvalid <= 1'b1;
    o_wvalid <= 1'b1;
    o_bready <= 1'b1;
    for (int n = 0; n < 64 && !done; n++) begin
      @(posedge i_sys_clk);
      if (o_awvalid && i_awready) begin
        o_awvalid <= 1'b0;
        o_awaddr <= ~a;
      end
      if (o_wvalid && i_wready) begin
        o_wvalid <= 1'b0;
        o_wdata <= ~d;
      end
      if (i_bvalid) begin
        o_bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) testbench.timeout_hit();
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a);
    logic done = 1'b0;
    @(posedge i_sys_clk);
    o_araddr <= a;
    o_arvalid <= 1'b1;
    o_rready <= 1'b1;
    for (int n = 0; n < 64 && !done; n++) begin
      @(posedge i_sys_clk);
      if (o_arvalid && i_arready) begin
        o_arvalid <= 1'b0;
        o_araddr <= ~a;
      end
      if (i_rvalid) begin
        o_rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) testbench.timeout_hit();
  endtask : rd
endmodule : hsr_ctrl_model

/* File: testbench/hsr_properties.sv */
// Bus and service request checks of the status block.
`timescale 1ns/10ps
module hsr_props (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [1:0] o_bresp,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [hsr_pkg::ADDR_W-1:0] i_araddr,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [hsr_pkg::DATA_W-1:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_srq,
  input wire logic o_irq
);
  import hsr_pkg::*;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_rd;
    i_arvalid && o_arready;
  endsequence
  sequence s_poll;
    s_rd ##0 (i_araddr == OFS_SPOLL && o_srq);
  endsequence
  a_top_zero: assert property (o_rvalid |-> o_rdata[31:15] == 17'h00000)
    else $error("high read bits set");
  a_rdata_holds: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
  a_bresp_holds: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write answer dropped");
  a_read_answer: assert property (s_rd |=> o_rvalid)
    else $error("no read answer");
  a_one_read: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while busy");
  a_err_no_data: assert property (o_rvalid && o_rresp == RESP_SLVERR |-> o_rdata == 32'h00000000)
    else $error("error read carries data");
  a_poll_rqs: assert property (s_poll |=> o_rdata[STB_RQS_BIT])
    else $error("poll lost request bit");
  a_reset_quiet: assert property ($past(i_rst) |-> !o_srq && !o_irq)
    else $error("request after reset");
endmodule : hsr_props
bind hsr_top hsr_props u_props (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .o_bvalid(o_bvalid), .i_bready(i_bready),
  .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr), .o_rvalid(o_rvalid),
  .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_srq(o_srq), .o_irq(o_irq));

/* File: testbench/testbench.sv */
// Self-checking bench of the status reporting block.
`timescale 1ns/10ps
module testbench;
  import hsr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, srq, irq;
  logic settle, err_av, msg_av;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [STAT_W-1:0] c [4];
  logic [STAT_W-1:0] rv;
  logic [BYTE_W-1:0] sev;
  logic [33:0] rq[$];
  logic [1:0] wq[$];
  int n_fail = 0;
  int samples_checked = 0;
  always #4 clk = ~clk;
  hsr_top dut (.i_sys_clk(clk), .i_rst(rst), .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
    .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
    .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_oper_cond(c[0]), .i_settling(settle),
    .i_ques_cond(c[1]), .i_freq_cond(c[2]), .i_pow_cond(c[3]), .i_std_event(sev), .i_err_avail(err_av),
    .i_msg_avail(msg_av), .o_srq(srq), .o_irq(irq));
  hsr_ctrl_model u_ctl (.i_sys_clk(clk), .i_awready(awready), .i_wready(wready), .i_bvalid(bvalid),
    .i_arready(arready), .i_rvalid(rvalid), .o_awvalid(awvalid), .o_awaddr(awaddr), .o_wvalid(wvalid),
    .o_wdata(wdata), .o_wstrb(wstrb), .o_bready(bready), .o_arvalid(arvalid), .o_araddr(araddr), .o_rready(rready));
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic [1:0] r = RESP_OKAY);
    rq.push_back({r, e});
    u_ctl.rd(a);
  endtask : rd
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] r = RESP_OKAY,
    input logic [3:0] s = 4'hf);
    wq.push_back(r);
    u_ctl.wr(a, d, s);
  endtask : wr
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  function automatic logic [ADDR_W-1:0] ga(input int g, input logic [4:0] o);
    return {1'b1, 2'(g), o};
  endfunction : ga
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  task automatic timeout_hit();
    n_fail++;
    complete_run();
  endtask : timeout_hit
  always @(posedge clk) begin
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    if (bvalid && bready) chk({bresp, 32'h0}, {wq.pop_front(), 32'h0});
  end
  initial begin
    c = '{default: 15'h0000};
    {settle, err_av, msg_av, sev} = 11'h000;
    void'($urandom(44644));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    idle(2);
    for (int g = 0; g < NUM_GRP; g++) begin
      rd(ga(g, GOFS_PTR), 32'h7fff);
      rd(ga(g, GOFS_NTR), 32'h0);
      rd(ga(g, GOFS_EVT), 32'h0);
      rd(ga(g, GOFS_EN), 32'h0);
    end
    rd(OFS_SRE, 32'h0);
    rd(OFS_ESE, 32'h0);
    rd(OFS_IRQ_MASK, 32'h0);
    $display("reset test done");
    for (int g = 0; g < NUM_GRP; g++) c[g] <= 15'($urandom());
    settle <= 1'b1;
    idle(4);
    rd(ga(GRP_OPER, GOFS_COND), {17'h0, c[0] | 15'h0002});
    rd(ga(GRP_QUES, GOFS_COND), {17'h0, c[1] & 15'h7fd7});
    rd(ga(GRP_FREQ, GOFS_COND), {17'h0, c[2]});
    rd(ga(GRP_POW, GOFS_COND), {17'h0, c[3]});
    c <= '{default: 15'h0000};
    settle <= 1'b0;
    idle(4);
    rd(ga(GRP_OPER, GOFS_COND), 32'h0);
    wr(OFS_CLS, 32'h0);
    $display("condition test done");
    rv = 15'($urandom()) | 15'h0001;
    wr(ga(GRP_FREQ, GOFS_EN), 32'hffff);
    rd(ga(GRP_FREQ, GOFS_EN), 32'h7fff);
    c[2] <= rv;
    idle(4);
    rd(ga(GRP_QUES, GOFS_COND), 32'h20);
    rd(ga(GRP_FREQ, GOFS_EVT), {17'h0, rv});
    rd(ga(GRP_FREQ, GOFS_EVT), 32'h0);
    wr(OFS_CLS, 32'h0);
    wr(ga(GRP_QUES, GOFS_EN), 32'h20);
    wr(OFS_SRE, 32'h08);
    wr(OFS_IRQ_MASK, 32'h1);
    wr(ga(GRP_FREQ, GOFS_PTR), 32'h0);
    wr(ga(GRP_FREQ, GOFS_NTR), 32'h7fff);
    c[2] <= 15'h0000;
    idle(10);
    chk(34'(srq), 34'h1);
    chk(34'(irq), 34'h1);
    rd(OFS_SPOLL, 32'h48);
    idle(2);
    chk(34'(srq), 34'h0);
    rd(OFS_STB, 32'h48);
    rd(OFS_SPOLL, 32'h08);
    $display("service request test done");
    rd(OFS_IRQ_STAT, 32'h3);
    wr(OFS_IRQ_MASK, 32'h0);
    idle(3);
    chk(34'(irq), 34'h0);
    wr(OFS_IRQ_MASK, 32'h2);
    idle(3);
    chk(34'(irq), 34'h1);
    wr(OFS_IRQ_STAT, 32'h3);
    idle(3);
    chk(34'(irq), 34'h0);
    wr(OFS_CLS, 32'h0);
    rd(ga(GRP_FREQ, GOFS_EVT), 32'h0);
    rd(ga(GRP_QUES, GOFS_EVT), 32'h0);
    $display("interrupt test done");
    wr(OFS_ESE, 32'h41);
    err_av <= 1'b1;
    msg_av <= 1'b1;
    sev <= 8'h41;
    @(posedge clk);
    sev <= 8'h00;
    idle(4);
    rd(OFS_STB, 32'h34);
    rd(OFS_ESR, 32'h41);
    rd(OFS_ESR, 32'h0);
    wr(OFS_SRE, 32'h00ff, RESP_OKAY, 4'h2);
    rd(OFS_SRE, 32'h08);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h44, 32'h1234, RESP_SLVERR);
    idle(4);
    $display("common register test done");
    complete_run();
  end
endmodule : testbench
